// [design/stp_bus_if.sv]
/*
 Open-drain two-wire bus between host and target; resolves wire levels from the enables.
 Assumes pull-ups: a line is high unless some party enables its low drive.
*/
`timescale 1ns/1ps
`default_nettype none

interface stp_bus_if;
    logic scl_host_oe;
    logic sda_host_oe;
    logic sda_tgt_oe;
    logic scl;
    logic sda;

    assign scl = ~scl_host_oe;
    assign sda = ~(sda_host_oe | sda_tgt_oe);

    modport target (input scl, input sda, output sda_tgt_oe);
    modport host (input scl, input sda, output scl_host_oe, output sda_host_oe);
endinterface

`default_nettype wire

// [design/stp_cfg.svh]
/*
 Constants of the sensor target port and its host: addresses, fill values, timing counts.
 Assumes a 40 MHz core clock; included by both ends and by the testbench.
*/
`ifndef STP_CFG_SVH
`define STP_CFG_SVH

`define STP_CLK_KHZ 40000
`define STP_ADDR_DEFAULT 7'h41
`define STP_PWR_REG 8'hE0
`define STP_PTR_RESET 8'h00
`define STP_RD_FILL 8'hFF
`define STP_DIR_WR 1'b0
`define STP_DIR_RD 1'b1
`define STP_ACK_BIT 4'h8
`define STP_LAST_TX_BIT 4'h7
`define STP_FILT_NS 50
`define STP_FILT_CYC ((`STP_FILT_NS * `STP_CLK_KHZ + 999999) / 1000000)
`define STP_RATE_STD_KBPS 100
`define STP_RATE_FAST_KBPS 400
`define STP_RATE_FMP_KBPS 1000
`define STP_QTR_CYC(k) ((`STP_CLK_KHZ + 4 * (k) - 1) / (4 * (k)))

`endif

// [design/stp_host.sv]
/*
 Host end of the two-wire port: runs write and read transactions from a command port.
 Assumes the target never stretches the clock; bit timing comes from a quarter-bit divider.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stp_cfg.svh"

module stp_host
    import stp_pkg::*;
#(
    parameter int RATE_KBPS = `STP_RATE_FMP_KBPS
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    // Two-wire bus
    stp_bus_if.host BUS,
    // Command
    input wire logic CMD_VALID_I,
    input wire logic CMD_RD_I,
    input wire logic CMD_USE_PTR_I,
    input wire logic [6:0] CMD_TADDR_I,
    input wire logic [7:0] CMD_PTR_I,
    input wire logic [7:0] CMD_LEN_I,
    input wire logic [7:0] WR_DATA_I,
    output logic CMD_READY_O,
    output logic WR_TAKE_O,
    output logic [7:0] RD_DATA_O,
    output logic RD_VALID_O,
    output logic DONE_O,
    output logic NACK_O
);

    localparam int QTR = `STP_QTR_CYC(RATE_KBPS);
    localparam int QW = $clog2(QTR);

    initial begin
        if (RATE_KBPS < 1 || RATE_KBPS > `STP_RATE_FMP_KBPS || QTR < 2) begin
            $error("RATE_KBPS not servable");
        end
    end

    logic [QW-1:0] tc_reg, tc_next;
    logic tick;
    assign tick = (tc_reg == QW'(QTR - 1));

    stp_hstate_e st_reg, st_next;
    stp_kind_e kind_reg, kind_next;
    logic [1:0] q_reg, q_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next, cnt_reg, cnt_next, ptr_reg, ptr_next;
    logic [6:0] ta_reg, ta_next;
    logic rd_reg, rd_next, scl_reg, scl_next, sda_reg, sda_next, ab_reg, ab_next;
    logic rdy_reg, rdy_next, take_reg, take_next, rdv_reg, rdv_next;
    logic done_reg, done_next, nack_reg, nack_next;
    logic [7:0] rdat_reg, rdat_next;
    logic load;

    always_comb begin
        tc_next = tick ? '0 : tc_reg + 1'b1;
        st_next = st_reg;
        kind_next = kind_reg;
        q_next = q_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        ptr_next = ptr_reg;
        ta_next = ta_reg;
        rd_next = rd_reg;
        scl_next = scl_reg;
        sda_next = sda_reg;
        ab_next = ab_reg;
        rdy_next = rdy_reg;
        nack_next = nack_reg;
        rdat_next = rdat_reg;
        take_next = 1'b0;
        rdv_next = 1'b0;
        done_next = 1'b0;
        load = 1'b0;
        if (st_reg == H_IDLE) begin
            tc_next = '0;
            q_next = '0;
            scl_next = 1'b0;
            sda_next = 1'b0;
            if (CMD_VALID_I && rdy_reg) begin
                rdy_next = 1'b0;
                rd_next = CMD_RD_I;
                ta_next = CMD_TADDR_I;
                ptr_next = CMD_PTR_I;
                cnt_next = CMD_LEN_I;
                nack_next = 1'b0;
                kind_next = (CMD_RD_I && !CMD_USE_PTR_I) ? K_AR : K_AW;
                st_next = H_START;
            end
        end else if (tick) begin
            q_next = q_reg + 2'h1;
            unique case (st_reg)
                H_START: begin
                    unique case (q_reg)
                        2'h0: sda_next = 1'b0;
                        2'h1: scl_next = 1'b0;
                        2'h2: sda_next = 1'b1;
                        default: begin
                            scl_next = 1'b1;
                            load = 1'b1;
                            st_next = H_BIT;
                        end
                    endcase
                end
                H_BIT: begin
                    unique case (q_reg)
                        2'h0: begin
                            if (bit_reg != `STP_ACK_BIT) begin
                                sda_next = ~sh_reg[7];
                            end else begin
                                sda_next = (kind_reg == K_RD) && (cnt_reg != 8'h00);
                            end
                        end
                        2'h1: scl_next = 1'b0;
                        2'h2: begin
                            if (bit_reg != `STP_ACK_BIT) begin
                                sh_next = {sh_reg[6:0], BUS.sda};
                            end else begin
                                ab_next = BUS.sda;
                            end
                        end
                        default: begin
                            scl_next = 1'b1;
                            bit_next = bit_reg + 4'h1;
                            if (bit_reg == `STP_ACK_BIT) begin
                                if (kind_reg != K_RD && ab_reg) begin
                                    nack_next = 1'b1;
                                    st_next = H_STOP;
                                end else begin
                                    unique case (kind_reg)
                                        K_AW: begin
                                            kind_next = K_PTR;
                                            load = 1'b1;
                                        end
                                        K_PTR: begin
                                            if (rd_reg) begin
                                                kind_next = K_AR;
                                                st_next = H_START;
                                            end else begin
                                                kind_next = K_WD;
                                                load = 1'b1;
                                            end
                                        end
                                        K_AR: begin
                                            kind_next = K_RD;
                                            load = 1'b1;
                                        end
                                        default: begin
                                            if (kind_reg == K_RD) begin
                                                rdat_next = sh_reg;
                                                rdv_next = 1'b1;
                                            end
                                            if (cnt_reg == 8'h00) begin
                                                st_next = H_STOP;
                                            end else begin
                                                cnt_next = cnt_reg - 8'h01;
                                                load = 1'b1;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                default: begin
                    unique case (q_reg)
                        2'h0: sda_next = 1'b1;
                        2'h1: scl_next = 1'b0;
                        2'h2: sda_next = 1'b0;
                        default: begin
                            st_next = H_IDLE;
                            rdy_next = 1'b1;
                            done_next = 1'b1;
                        end
                    endcase
                end
            endcase
        end
        // Next byte: direction bit follows the kind, read bytes leave the line released
        if (load) begin
            bit_next = '0;
            unique case (kind_next)
                K_AW: sh_next = {ta_reg, `STP_DIR_WR};
                K_PTR: sh_next = ptr_reg;
                K_AR: sh_next = {ta_reg, `STP_DIR_RD};
                K_WD: begin
                    sh_next = WR_DATA_I;
                    take_next = 1'b1;
                end
                default: sh_next = `STP_RD_FILL;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tc_reg <= '0;
            st_reg <= H_IDLE;
            kind_reg <= K_AW;
            q_reg <= '0;
            bit_reg <= '0;
            sh_reg <= '0;
            cnt_reg <= '0;
            ptr_reg <= '0;
            ta_reg <= '0;
            rd_reg <= 1'b0;
            scl_reg <= 1'b0;
            sda_reg <= 1'b0;
            ab_reg <= 1'b0;
            rdy_reg <= 1'b1;
            take_reg <= 1'b0;
            rdv_reg <= 1'b0;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            rdat_reg <= '0;
        end else begin
            tc_reg <= tc_next;
            st_reg <= st_next;
            kind_reg <= kind_next;
            q_reg <= q_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            ptr_reg <= ptr_next;
            ta_reg <= ta_next;
            rd_reg <= rd_next;
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            ab_reg <= ab_next;
            rdy_reg <= rdy_next;
            take_reg <= take_next;
            rdv_reg <= rdv_next;
            done_reg <= done_next;
            nack_reg <= nack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign BUS.scl_host_oe = scl_reg;
    assign BUS.sda_host_oe = sda_reg;
    assign CMD_READY_O = rdy_reg;
    assign WR_TAKE_O = take_reg;
    assign RD_DATA_O = rdat_reg;
    assign RD_VALID_O = rdv_reg;
    assign DONE_O = done_reg;
    assign NACK_O = nack_reg;

endmodule // stp_host

`default_nettype wire

// [design/stp_pkg.sv]
/*
 Types shared by both ends of the sensor target port: state and byte-kind enums.
 Assumes stp_cfg.svh for the numeric constants.
*/
package stp_pkg;

    typedef enum logic [6:0] {
        T_IDLE = 7'h01,
        T_ADDR = 7'h02,
        T_RXB = 7'h04,
        T_ACK = 7'h08,
        T_TXLD = 7'h10,
        T_TXB = 7'h20,
        T_HACK = 7'h40
    } stp_tstate_e;

    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_START = 4'h2,
        H_BIT = 4'h4,
        H_STOP = 4'h8
    } stp_hstate_e;

    typedef enum logic [2:0] {
        K_AW = 3'h0,
        K_PTR = 3'h1,
        K_WD = 3'h2,
        K_AR = 3'h3,
        K_RD = 3'h4
    } stp_kind_e;

endpackage

// [design/stp_target.sv]
/*
 Target end of the two-wire port: address match, pointer byte, register read/write strobes.
 Assumes bus levels synchronous to CORE_CLK_I and register data valid while REG_RD_O is high.
*/
// Contract
// - Answer 7-bit address, default 0x41
// - Work at 100k, 400k, 1M bit rates
// - 8-bit pointer increments after every data byte
// - Pointer survives stop until new pointer byte
// - Read without pointer continues at pointer
// - Host write: start, addr+0, pointer, data, stop
// - Drive ACK/NACK on 9th clock pulse
// - Host may stop after a NACK
// - Host read: pointer write, repeated start, addr+1
// - Host ACKs all but last, NACK, stop
// - Target address reprogrammable any time
// - Host enables devices one at a time
// - Tolerate newer bus traffic, legacy mode only
// - In standby only power register accessible
`timescale 1ns/1ps
`default_nettype none
`include "stp_cfg.svh"

module stp_target
    import stp_pkg::*;
#(
    parameter int FILT_CYC = `STP_FILT_CYC,
    parameter logic [6:0] ADDR_DEFAULT = `STP_ADDR_DEFAULT
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    // Two-wire bus
    stp_bus_if.target BUS,
    // Address programming
    input wire logic ADDR_LOAD_I,
    input wire logic [6:0] ADDR_NEW_I,
    // Power state
    input wire logic STANDBY_I,
    // Register access
    input wire logic [7:0] REG_RDATA_I,
    output logic [7:0] REG_ADDR_O,
    output logic [7:0] REG_WDATA_O,
    output logic REG_WR_O,
    output logic REG_RD_O,
    // Status
    output logic [6:0] TGT_ADDR_O
);

    localparam int FW = $clog2(FILT_CYC + 1);

    initial begin
        if (FILT_CYC < 1 || FILT_CYC > 8) begin
            $error("FILT_CYC out of range");
        end
    end

    // Spike filter keeps short pulses of faster bus generations from clocking the port
    wire [1:0] raw;
    wire [1:0] filt;
    assign raw = {BUS.scl, BUS.sda};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_filt
            logic f_reg;
            logic f_next;
            logic [FW-1:0] c_reg;
            logic [FW-1:0] c_next;
            always_comb begin
                f_next = f_reg;
                c_next = '0;
                if (raw[g] != f_reg) begin
                    if (c_reg == FW'(FILT_CYC - 1)) begin
                        f_next = raw[g];
                    end else begin
                        c_next = c_reg + 1'b1;
                    end
                end
            end
            always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    f_reg <= 1'b1;
                    c_reg <= '0;
                end else begin
                    f_reg <= f_next;
                    c_reg <= c_next;
                end
            end
            assign filt[g] = f_reg;
        end
    endgenerate

    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic allow;
    assign scl_f = filt[1];
    assign sda_f = filt[0];
    assign start = scl_f & scl_q & sda_q & ~sda_f;
    assign stop = scl_f & scl_q & ~sda_q & sda_f;
    assign rise = scl_f & ~scl_q;
    assign fall = ~scl_f & scl_q;

    stp_tstate_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] wd_reg, wd_next;
    logic [6:0] addr_reg, addr_next;
    logic rw_reg, rw_next;
    logic first_reg, first_next;
    logic oe_reg, oe_next;
    logic ackd_reg, ackd_next;
    logic wr_reg, wr_next;
    logic rd_reg, rd_next;
    logic [7:0] tx_byte;
    // Standby leaves only the power register reachable
    assign allow = ~STANDBY_I | (ptr_reg == `STP_PWR_REG);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        wd_next = wd_reg;
        addr_next = addr_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        oe_next = oe_reg;
        ackd_next = ackd_reg;
        wr_next = 1'b0;
        rd_next = 1'b0;
        tx_byte = allow ? REG_RDATA_I : `STP_RD_FILL;
        if (ADDR_LOAD_I) begin
            addr_next = ADDR_NEW_I;
        end
        // Start, including a repeated one, wins over any byte in progress
        if (start) begin
            state_next = T_ADDR;
            cnt_next = '0;
            oe_next = 1'b0;
        end else if (stop) begin
            state_next = T_IDLE;
            oe_next = 1'b0;
        end else begin
            unique case (state_reg)
                T_IDLE: begin
                end
                T_ADDR, T_RXB: begin
                    if (rise) begin
                        sh_next = {sh_reg[6:0], sda_f};
                        cnt_next = cnt_reg + 1'b1;
                    end else if (fall && cnt_reg == `STP_ACK_BIT) begin
                        cnt_next = '0;
                        if (state_reg == T_ADDR) begin
                            if (sh_reg[7:1] == addr_reg) begin
                                rw_next = sh_reg[0];
                                first_next = (sh_reg[0] == `STP_DIR_WR);
                                oe_next = 1'b1;
                                state_next = T_ACK;
                            end else begin
                                state_next = T_IDLE;
                            end
                        end else if (first_reg) begin
                            ptr_next = sh_reg;
                            first_next = 1'b0;
                            oe_next = 1'b1;
                            state_next = T_ACK;
                        end else begin
                            if (allow) begin
                                wr_next = 1'b1;
                                wd_next = sh_reg;
                                oe_next = 1'b1;
                            end
                            ptr_next = ptr_reg + 8'h01;
                            state_next = T_ACK;
                        end
                    end
                end
                T_ACK: begin
                    if (fall) begin
                        oe_next = 1'b0;
                        if (rw_reg == `STP_DIR_RD) begin
                            rd_next = allow;
                            state_next = T_TXLD;
                        end else begin
                            state_next = T_RXB;
                        end
                    end
                end
                T_TXLD: begin
                    sh_next = tx_byte;
                    oe_next = ~tx_byte[7];
                    ptr_next = ptr_reg + 8'h01;
                    cnt_next = '0;
                    state_next = T_TXB;
                end
                T_TXB: begin
                    if (fall) begin
                        if (cnt_reg == `STP_LAST_TX_BIT) begin
                            oe_next = 1'b0;
                            ackd_next = 1'b0;
                            state_next = T_HACK;
                        end else begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_next = ~sh_reg[6];
                            cnt_next = cnt_reg + 1'b1;
                        end
                    end
                end
                T_HACK: begin
                    if (rise) begin
                        ackd_next = ~sda_f;
                    end else if (fall) begin
                        if (ackd_reg) begin
                            rd_next = allow;
                            state_next = T_TXLD;
                        end else begin
                            state_next = T_IDLE;
                        end
                    end
                end
                default: begin
                    state_next = T_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_reg <= T_IDLE;
            cnt_reg <= '0;
            sh_reg <= '0;
            ptr_reg <= `STP_PTR_RESET;
            wd_reg <= '0;
            addr_reg <= ADDR_DEFAULT;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            oe_reg <= 1'b0;
            ackd_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            ptr_reg <= ptr_next;
            wd_reg <= wd_next;
            addr_reg <= addr_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            oe_reg <= oe_next;
            ackd_reg <= ackd_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    assign BUS.sda_tgt_oe = oe_reg;
    assign REG_ADDR_O = ptr_reg;
    assign REG_WDATA_O = wd_reg;
    assign REG_WR_O = wr_reg;
    assign REG_RD_O = rd_reg;
    assign TGT_ADDR_O = addr_reg;

endmodule // stp_target

`default_nettype wire

// [verif/stp_bus_sva.sv]
/*
 Bus checker for the target end: when and how long the target pulls the data line.
 Assumes it sits beside the interface that joins host and target, on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module stp_bus_sva (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    // Bus lines
    input wire logic scl_host_oe,
    input wire logic sda_host_oe,
    input wire logic sda_tgt_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q_reg;
    logic [3:0] rise_cnt_reg;
    logic [3:0] rise_cnt_next;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    // Clock rises seen while the target holds the line; saturates so it never wraps
    always_comb begin
        rise_cnt_next = rise_cnt_reg;
        if (!sda_tgt_oe) begin
            rise_cnt_next = 4'h0;
        end else if (!scl_host_oe && !scl_q_reg && rise_cnt_reg != 4'hF) begin
            rise_cnt_next = rise_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            scl_q_reg <= 1'b1;
            rise_cnt_reg <= 4'h0;
        end else begin
            scl_q_reg <= scl;
            rise_cnt_reg <= rise_cnt_next;
        end
    end

    sequence start_s;
        scl && $fell(sda);
    endsequence
    sequence stop_s;
        scl && $rose(sda);
    endsequence

    tgt_edge_low_a: assert property ($changed(sda_tgt_oe) |-> !scl)
        else $error("target changed data line while clock high");
    drive_lag_a: assert property ($rose(sda_tgt_oe) |-> !$past(scl, 2))
        else $error("target drove too soon after clock fall");
    sda_steady_a: assert property (scl && $past(scl) && $stable(sda_host_oe) |-> $stable(sda))
        else $error("data line moved during clock high");
    start_quiet_a: assert property (start_s |-> !sda_tgt_oe)
        else $error("target drove data at a start");
    addr_quiet_a: assert property (start_s |=> !sda_tgt_oe [*8])
        else $error("target drove data during address bits");
    stop_idle_a: assert property (stop_s |=> !sda_tgt_oe [*8])
        else $error("target drove data after a stop");
    reset_quiet_a: assert property ($rose(ARST_N_I) |-> !sda_tgt_oe [*3])
        else $error("target drove data after reset");
    drive_span_a: assert property (rise_cnt_reg <= 4'h9)
        else $error("target held data line over nine clocks");
endmodule // stp_bus_sva

`default_nettype wire

// [verif/tb_sensor_i2c_target_port.sv]
/*
 Testbench joining both ends; drives host commands, checks register strobes.
 Assumes a 40 MHz clock, the host at 1 Mbit/s, and a register stand-in of address xor 5A.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stp_cfg.svh"

module tb_sensor_i2c_target_port;
    logic clk, arst_n, addr_load, stby, cmd_valid, cmd_rd, cmd_use_ptr;
    logic reg_wr, reg_rd, cmd_ready, wr_take, rd_valid, done, nack;
    logic [6:0] addr_new, cmd_taddr, tgt_addr;
    logic [7:0] cmd_ptr, cmd_len, wr_data, rdata, reg_addr, reg_wdata, rd_data;
    logic [7:0] rdq[$], wrq[$], waq[$], raq[$];
    int fail_count, check_count;

    stp_bus_if bus();
    assign rdata = reg_addr ^ 8'h5A;

    stp_target stp_target_inst (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .BUS(bus),
        .ADDR_LOAD_I(addr_load), .ADDR_NEW_I(addr_new), .STANDBY_I(stby),
        .REG_RDATA_I(rdata), .REG_ADDR_O(reg_addr), .REG_WDATA_O(reg_wdata),
        .REG_WR_O(reg_wr), .REG_RD_O(reg_rd), .TGT_ADDR_O(tgt_addr));
    stp_host stp_host_inst (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .BUS(bus),
        .CMD_VALID_I(cmd_valid), .CMD_RD_I(cmd_rd), .CMD_USE_PTR_I(cmd_use_ptr),
        .CMD_TADDR_I(cmd_taddr), .CMD_PTR_I(cmd_ptr), .CMD_LEN_I(cmd_len),
        .WR_DATA_I(wr_data), .CMD_READY_O(cmd_ready), .WR_TAKE_O(wr_take),
        .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .DONE_O(done), .NACK_O(nack));
    stp_bus_sva stp_bus_sva_inst (.CORE_CLK_I(clk), .ARST_N_I(arst_n),
        .scl_host_oe(bus.scl_host_oe), .sda_host_oe(bus.sda_host_oe),
        .sda_tgt_oe(bus.sda_tgt_oe), .scl(bus.scl), .sda(bus.sda));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Pulses are sampled mid-cycle, while they stand
    always @(negedge clk) begin
        if (wr_take === 1'b1) wr_data <= wr_data + 8'h01;
        if (rd_valid === 1'b1) rdq.push_back(rd_data);
        if (reg_rd === 1'b1) raq.push_back(reg_addr);
        if (reg_wr === 1'b1) begin
            wrq.push_back(reg_wdata);
            waq.push_back(reg_addr - 8'h01);
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic run(input logic rd, input logic up, input logic [6:0] ta,
                       input logic [7:0] ptr, input logic [7:0] len, input logic [7:0] wd);
        int n;
        rdq.delete(); wrq.delete(); waq.delete(); raq.delete();
        @(negedge clk);
        cmd_rd = rd; cmd_use_ptr = up; cmd_taddr = ta; cmd_ptr = ptr; cmd_len = len;
        wr_data = wd;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 8000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 8000) begin
            fail_count++;
            $display("[ERR] %0t command never finished", $time);
            conclude();
        end
    endtask

    task automatic t_write;
        run(1'b0, 1'b1, 7'h41, 8'h10, 8'h02, 8'hC3);
        chk({6'h0, cmd_ready, nack}, 8'h02);
        chk(8'(wrq.size()), 8'h03);
        for (int i = 0; i < 3; i++) chk(waq[i], 8'h10 + 8'(i));
        for (int i = 0; i < 3; i++) chk(wrq[i], 8'hC3 + 8'(i));
    endtask

    task automatic t_read;
        run(1'b1, 1'b1, 7'h41, 8'h20, 8'h02, 8'h00);
        chk(8'(rdq.size()), 8'h03);
        chk(raq[2], 8'h22);
        for (int i = 0; i < 3; i++) chk(rdq[i], (8'h20 + 8'(i)) ^ 8'h5A);
        chk({7'h0, nack}, 8'h00);
        run(1'b1, 1'b0, 7'h41, 8'h00, 8'h01, 8'h00);
        for (int i = 0; i < 2; i++) chk(rdq[i], (8'h23 + 8'(i)) ^ 8'h5A);
        chk(reg_addr, 8'h25);
    endtask

    task automatic t_wrong;
        run(1'b0, 1'b1, 7'h42, 8'h50, 8'h00, 8'h11);
        chk({7'h0, nack}, 8'h01);
        chk(8'(wrq.size()), 8'h00);
        chk(reg_addr, 8'h25);
    endtask

    task automatic t_newaddr;
        @(negedge clk);
        addr_new = 7'h2A;
        addr_load = 1'b1;
        @(negedge clk);
        addr_load = 1'b0;
        chk({1'b0, tgt_addr}, 8'h2A);
        run(1'b0, 1'b1, 7'h41, 8'h40, 8'h00, 8'h77);
        chk({7'h0, nack}, 8'h01);
        run(1'b0, 1'b1, 7'h2A, 8'h40, 8'h00, 8'h77);
        chk(waq[0], 8'h40);
    endtask

    task automatic t_standby;
        stby = 1'b1;
        run(1'b1, 1'b1, 7'h2A, 8'h30, 8'h00, 8'h00);
        chk(rdq[0], `STP_RD_FILL);
        chk(8'(raq.size()), 8'h00);
        run(1'b0, 1'b1, 7'h2A, 8'h31, 8'h00, 8'h12);
        chk({7'h0, nack}, 8'h01);
        run(1'b0, 1'b1, 7'h2A, `STP_PWR_REG, 8'h00, 8'h01);
        chk(waq[0], `STP_PWR_REG);
        stby = 1'b0;
    endtask

    initial begin
        arst_n = 1'b0; addr_load = 1'b0; addr_new = 7'h00; stby = 1'b0;
        cmd_valid = 1'b0; cmd_rd = 1'b0; cmd_use_ptr = 1'b0; cmd_taddr = 7'h00;
        cmd_ptr = 8'h00; cmd_len = 8'h00; wr_data = 8'h00;
        fail_count = 0; check_count = 0;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({1'b0, tgt_addr}, {1'b0, `STP_ADDR_DEFAULT});
        chk(reg_addr, `STP_PTR_RESET);
        t_write();
        t_read();
        t_wrong();
        t_newaddr();
        t_standby();
        conclude();
    end
endmodule // tb_sensor_i2c_target_port

`default_nettype wire
